// *** hdl/pcc_pkg.sv ***
// constants and types shared by the processor clock control block
package pcc_pkg;

  // register port
  localparam logic [15:0] PCC_CTRL_ADDR    = 16'h1072;
  localparam int          PCC_SRC_BIT      = 15;
  localparam int          PCC_NOM_LSB      = 12;
  localparam int          PCC_AUT_BIT      = 11;
  localparam int          PCC_ALT_LSB      = 8;
  localparam int          PCC_EXT_LSB      = 4;
  localparam int          PCC_STOP_ON_HALT_HOLD_BIT_BIT     = 1;
  localparam int          PCC_SCH_BIT      = 0;

  // reset values
  localparam logic [2:0]  PCC_NOM_RST      = 3'h0;
  localparam logic [2:0]  PCC_NOM_OUT_DEF  = 3'h1;
  localparam logic [2:0]  PCC_ALT_RST      = 3'h0;
  localparam logic [3:0]  PCC_EXT_RST      = 4'h0;
  localparam logic [2:0]  PCC_MUX_STRAP    = 3'h4;

  // speed codes
  localparam logic [2:0]  PCC_SPD_NOMINAL  = 3'h0;
  localparam logic [2:0]  PCC_SPD_INPUT    = 3'h0;

  // timing
  localparam int          PCC_CLK_PERIOD_NS = 10;
  localparam int          PCC_US_NS         = 1000;
  localparam logic [10:0] PCC_CYC_PER_US    = 11'(PCC_US_NS / PCC_CLK_PERIOD_NS);
  localparam logic [1:0]  PCC_STRAP_WAIT    = 2'h3;
  localparam logic [4:0]  PCC_DIR_HOLD_CYC  = 5'h10;

  typedef enum logic [1:0] {
    PCC_ST_RUN     = 2'h0,
    PCC_ST_STOPPED = 2'h1
  } pcc_state_t;

endpackage : pcc_pkg

// *** hdl/pcc_clk_div.sv ***
// processor clock divider with glitch-free start and stop
`timescale 1ns/10ps
module pcc_clk_div
  import pcc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] code_i,
  output logic            proc_clk_o,
  output logic            running_o
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] per_m1;
    logic [3:0] high;
    logic       running;
    logic       out;
  } pcc_div_st_t;

  pcc_div_st_t s_r;
  pcc_div_st_t s_nxt;

  logic [3:0] per_m1_sel;
  logic [3:0] high_sel;

  // period and high time in core cycles; source rate is core_clk / 2
  always_comb begin
    per_m1_sel = 4'h1;
    high_sel   = 4'h1;
    case (code_i)
      3'h2: begin per_m1_sel = 4'h3; high_sel = 4'h2;  end
      3'h3: begin per_m1_sel = 4'h7; high_sel = 4'h2;  end
      3'h4: begin per_m1_sel = 4'h7; high_sel = 4'h6;  end
      3'h5: begin per_m1_sel = 4'hf; high_sel = 4'h2;  end
      3'h6: begin per_m1_sel = 4'hf; high_sel = 4'he;  end
      default: begin per_m1_sel = 4'h1; high_sel = 4'h1; end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // new rate, start and stop take effect only at the end of the low phase
    if (!s_r.running || s_r.cnt == s_r.per_m1) begin  // see RULE17
      s_nxt.cnt     = 4'h0;
      s_nxt.per_m1  = per_m1_sel;
      s_nxt.high    = high_sel;
      s_nxt.running = run_i;
    end else begin
      s_nxt.cnt = s_r.cnt + 4'h1;
    end
    s_nxt.out = s_nxt.running && (s_nxt.cnt < s_nxt.high);  // see RULE1
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign proc_clk_o = s_r.out;
  assign running_o  = s_r.running;

endmodule : pcc_clk_div

// *** hdl/pcc_clock_ctrl.sv ***
// processor clock slowdown, hold extension and clock stop control
`timescale 1ns/10ps
// Operation
// RULE1 - alternate speed code picks nominal, undivided, /2, /4 or /8 with duty choice
// RULE2 - hold extension code stretches hold after refresh by that many microseconds
// RULE3 - input_a asserted forces hold extension to zero
// RULE4 - input_a released restores the programmed hold extension
// RULE5 - software writes zero to reserved bits 3 and 2
// RULE6 - stop-on-halt-hold bit stops clock at next halt with hold
// RULE7 - after wake the halt-hold stop bit stays set and stops again
// RULE8 - stop-on-hold bit stops clock at next hold cycle
// RULE9 - unmasked interrupt or nmi restarts clock and clears stop-on-hold bit
// RULE10 - refresh keeps running while the processor clock is stopped
// RULE11 - use clock stop only when this block generates the processor clock
// RULE12 - system reset clears stop bits, alternate speed and hold extension
// RULE13 - multiplexer select outputs show 100 throughout system reset
// RULE14 - strap at select 100 low keeps clock pin output, nominal undivided
// RULE15 - strap high starts clock pin as output then turns it to input
// RULE16 - without auto switching input_a picks nominal or alternate speed
// RULE17 - clock starts and stops only on a phase boundary
module pcc_clock_ctrl
  import pcc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        sys_rst_i,
  input  wire logic        input_a_i,
  input  wire logic        halt_i,
  input  wire logic        hold_i,
  input  wire logic        mux_req_i,
  input  wire logic        irq_i,
  input  wire logic        nmi_i,
  input  wire logic        refresh_busy_i,
  input  wire logic [2:0]  mux_sel_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [15:0] io_wdata_i,
  output logic [15:0]      io_rdata_o,
  output logic [2:0]       mux_sel_o,
  output logic             proc_clk_o,
  output logic             proc_clk_oe_o,
  output logic             proc_clk_stopped_o,
  output logic             hold_req_o,
  output logic             refresh_req_o
);

  typedef struct packed {
    logic       rst_m;
    logic       rst_s;
    logic       input_a_m;
    logic       input_a_s;
    logic       halt_m;
    logic       halt_s;
    logic       hold_m;
    logic       hold_s;
    logic       req_m;
    logic       req_s;
    logic       src;
    logic [2:0] nom;
    logic       aut;
    logic [2:0] alt;
    logic [3:0] ext;
    logic       stop_on_halt_hold_bit;
    logic       stop_on_hold_bit;
    pcc_state_t state;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic [4:0] dir_cnt;
    logic       busy_d;
    logic [10:0] ext_cnt;
    logic [15:0] rdata;
  } pcc_st_t;

  pcc_st_t s_r;
  pcc_st_t s_nxt;

  logic [2:0] speed_code;
  logic [3:0] ext_eff;
  logic       dir_hold;
  logic       wake;
  logic       stop_cond;
  logic       ctrl_hit;
  logic       div_running;

  // input_a asserted runs nominal speed; released runs the alternate setting
  always_comb begin
    speed_code = s_r.nom;
    if (!s_r.input_a_s && s_r.alt != PCC_SPD_NOMINAL) begin  // see RULE16
      speed_code = s_r.alt;  // see RULE1
    end
  end

  assign ext_eff   = s_r.input_a_s ? 4'h0 : s_r.ext;  // see RULE3 see RULE4
  assign dir_hold  = s_r.dir_cnt != 5'h0;
  assign wake      = irq_i || nmi_i;
  assign stop_cond = (s_r.stop_on_halt_hold_bit && s_r.halt_s && s_r.hold_s)  // see RULE6
                  || (s_r.stop_on_hold_bit && s_r.hold_s);                // see RULE8
  assign ctrl_hit  = io_addr_i == PCC_CTRL_ADDR;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_m   = sys_rst_i;
    s_nxt.rst_s   = s_r.rst_m;
    s_nxt.input_a_m = input_a_i;
    s_nxt.input_a_s = s_r.input_a_m;
    s_nxt.halt_m  = halt_i;
    s_nxt.halt_s  = s_r.halt_m;
    s_nxt.hold_m  = hold_i;
    s_nxt.hold_s  = s_r.hold_m;
    s_nxt.req_m   = mux_req_i;
    s_nxt.req_s   = s_r.req_m;
    s_nxt.busy_d  = refresh_busy_i;

    // register write; reserved bits 3 and 2 are dropped
    if (io_wr_i && ctrl_hit) begin  // see RULE5
      s_nxt.src  = io_wdata_i[PCC_SRC_BIT];
      s_nxt.nom  = io_wdata_i[PCC_NOM_LSB +: 3];
      s_nxt.aut  = io_wdata_i[PCC_AUT_BIT];
      s_nxt.alt  = io_wdata_i[PCC_ALT_LSB +: 3];
      s_nxt.ext  = io_wdata_i[PCC_EXT_LSB +: 4];
      s_nxt.stop_on_halt_hold_bit = io_wdata_i[PCC_STOP_ON_HALT_HOLD_BIT_BIT];
      s_nxt.stop_on_hold_bit  = io_wdata_i[PCC_SCH_BIT];
    end

    // clock stop and restart
    case (s_r.state)
      PCC_ST_RUN: begin
        if (stop_cond && !wake) begin
          s_nxt.state = PCC_ST_STOPPED;
        end
      end
      // wake beats a stop seen in the same cycle; a software write of the hold stop bit beats the clear
      PCC_ST_STOPPED: begin
        if (wake) begin
          s_nxt.state = PCC_ST_RUN;  // see RULE7
          if (!(io_wr_i && ctrl_hit)) begin
            s_nxt.stop_on_hold_bit = 1'b0;  // see RULE9
          end
        end
      end
      default: s_nxt.state = PCC_ST_RUN;
    endcase

    // hold extension after each refresh
    // input_a drops a running extension at once so the switch acts without delay
    if (s_r.input_a_s) begin
      s_nxt.ext_cnt = 11'h0;  // see RULE3
    end else if (s_r.busy_d && !refresh_busy_i) begin
      s_nxt.ext_cnt = 11'(ext_eff) * PCC_CYC_PER_US;  // see RULE2
    end else if (s_r.ext_cnt != 11'h0) begin
      s_nxt.ext_cnt = s_r.ext_cnt - 11'h1;
    end

    // strap sampling and pin direction after system reset
    // req_s lags the pin by two flops; the select has shown 100 for the whole wait
    if (!s_r.strap_done) begin
      if (s_r.strap_cnt == PCC_STRAP_WAIT) begin
        s_nxt.strap_done = 1'b1;
        if (s_r.req_s) begin
          s_nxt.nom     = PCC_SPD_INPUT;  // see RULE15
          s_nxt.dir_cnt = PCC_DIR_HOLD_CYC;
        end else begin
          s_nxt.nom = PCC_NOM_OUT_DEF;  // see RULE14
        end
      end else begin
        s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      end
    end else if (dir_hold) begin
      s_nxt.dir_cnt = s_r.dir_cnt - 5'h1;
    end

    s_nxt.rdata = 16'h0;
    if (io_rd_i && ctrl_hit) begin
      s_nxt.rdata = {s_r.src, s_r.nom, s_r.aut, s_r.alt, s_r.ext, 2'h0, s_r.stop_on_halt_hold_bit, s_r.stop_on_hold_bit};
    end

    // system reset restores defaults and restarts strap sampling
    if (s_r.rst_s) begin  // see RULE12
      s_nxt.src        = 1'b0;
      s_nxt.nom        = PCC_NOM_RST;
      s_nxt.aut        = 1'b0;
      s_nxt.alt        = PCC_ALT_RST;
      s_nxt.ext        = PCC_EXT_RST;
      s_nxt.stop_on_halt_hold_bit       = 1'b0;
      s_nxt.stop_on_hold_bit        = 1'b0;
      s_nxt.state      = PCC_ST_RUN;
      s_nxt.strap_cnt  = 2'h0;
      s_nxt.strap_done = 1'b0;
      s_nxt.dir_cnt    = 5'h0;
      s_nxt.ext_cnt    = 11'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r       <= '0;
      s_r.state <= PCC_ST_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // stop requests reach the divider only through run_i, which it takes at the end of a low phase
  pcc_clk_div u_div (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .run_i      (s_r.state == PCC_ST_RUN),  // see RULE17
    .code_i     (speed_code),
    .proc_clk_o (proc_clk_o),
    .running_o  (div_running)
  );

  // pin is driven during reset, while the strap delay and then the direction hold run, or for output codes
  assign proc_clk_oe_o      = s_r.rst_s || !s_r.strap_done || dir_hold || speed_code != PCC_SPD_INPUT;  // see RULE15
  assign mux_sel_o          = (s_r.rst_s || !s_r.strap_done) ? PCC_MUX_STRAP : mux_sel_i;  // see RULE13
  assign proc_clk_stopped_o = !div_running;
  assign hold_req_o         = refresh_busy_i || s_r.ext_cnt != 11'h0;
  assign refresh_req_o      = refresh_busy_i;  // see RULE10
  assign io_rdata_o         = s_r.rdata;

endmodule : pcc_clock_ctrl

// *** tb/pcc_clock_ctrl_props.sv ***
// port-level assertions for the processor clock control block
`timescale 1ns/10ps
module pcc_clock_ctrl_props
  import pcc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        sys_rst_i,
  input wire logic        input_a_i,
  input wire logic        irq_i,
  input wire logic        refresh_busy_i,
  input wire logic        io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic [2:0]  mux_sel_o,
  input wire logic        proc_clk_o,
  input wire logic        proc_clk_oe_o,
  input wire logic        proc_clk_stopped_o,
  input wire logic        hold_req_o,
  input wire logic        refresh_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rfsh; refresh_req_o == refresh_busy_i; endproperty
  a_rfsh: assert property (p_rfsh) else $error("refresh request not following busy");
  property p_hold_busy; refresh_busy_i |-> hold_req_o; endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("hold request low during refresh");
  property p_input_a; input_a_i [*4] |-> hold_req_o == refresh_busy_i; endproperty
  a_input_a: assert property (p_input_a) else $error("hold extended while input_a");
  property p_mux_rst; sys_rst_i [*3] |-> mux_sel_o == PCC_MUX_STRAP; endproperty
  a_mux_rst: assert property (p_mux_rst) else $error("select not 100 in reset");
  property p_oe_rst; sys_rst_i [*3] |-> proc_clk_oe_o; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("clock pin not driven in reset");
  property p_stop_low; proc_clk_stopped_o |-> !proc_clk_o && !$past(proc_clk_o); endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped clock not low");
  property p_wake; proc_clk_stopped_o && irq_i |-> ##[1:4] !proc_clk_stopped_o; endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not restart clock");
  property p_rd_idle;
    !($past(io_rd_i) && $past(io_addr_i) == PCC_CTRL_ADDR) |-> io_rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rsvd; io_rdata_o[3:2] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
endmodule : pcc_clock_ctrl_props
bind pcc_clock_ctrl pcc_clock_ctrl_props u_props (.core_clk_i, .arst_n_i, .sys_rst_i, .input_a_i, .irq_i,
  .refresh_busy_i, .io_rd_i, .io_addr_i, .io_rdata_o, .mux_sel_o, .proc_clk_o, .proc_clk_oe_o,
  .proc_clk_stopped_o, .hold_req_o, .refresh_req_o);

// *** tb/pcc_cpu_model.sv ***
// behavioural processor core fed by the generated clock
`timescale 1ns/10ps
module pcc_cpu_model (
  input  wire logic proc_clk_i,
  input  wire logic want_halt_i,
  input  wire logic want_hold_i,
  output logic      halt_o,
  output logic      hold_o
);
  initial begin
    halt_o = 1'b0;
    hold_o = 1'b0;
  end
  // status moves only on its own clock, so a stopped clock freezes it
  always @(posedge proc_clk_i) begin
    halt_o <= want_halt_i;
    hold_o <= want_hold_i;
  end
endmodule : pcc_cpu_model

// *** tb/pcc_clock_ctrl_bench.sv ***
// self-checking bench for the processor clock control block
`timescale 1ns/10ps
module pcc_clock_ctrl_bench;
  import pcc_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, sys_rst = 1'b1, input_a = 1'b0, mux_req = 1'b0, irq = 1'b0;
  logic        nmi = 1'b0, busy = 1'b0, wr = 1'b0, rd = 1'b0, w_halt = 1'b0, w_hold = 1'b0;
  logic        pclk, oe, stp, hreq, rreq, halt, hold;
  logic [2:0]  msel = 3'h0, mux_o;
  logic [15:0] addr = 16'h0, wdat = 16'h0, rdat, v;
  int          n_mismatch = 0, cmp_count = 0, n, hi, tot, c;
  int          per[1:6] = '{2, 4, 8, 8, 16, 16};
  int          hig[1:6] = '{1, 2, 2, 6, 2, 14};
  pcc_clock_ctrl u_dut (.core_clk_i(clk), .arst_n_i(arst_n), .sys_rst_i(sys_rst), .input_a_i(input_a),
    .halt_i(halt), .hold_i(hold), .mux_req_i(mux_req), .irq_i(irq), .nmi_i(nmi), .refresh_busy_i(busy),
    .mux_sel_i(msel), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdat), .io_rdata_o(rdat),
    .mux_sel_o(mux_o), .proc_clk_o(pclk), .proc_clk_oe_o(oe), .proc_clk_stopped_o(stp),
    .hold_req_o(hreq), .refresh_req_o(rreq));
  pcc_cpu_model u_cpu (.proc_clk_i(pclk), .want_halt_i(w_halt), .want_hold_i(w_hold), .halt_o(halt),
    .hold_o(hold));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    cyc(1);
    addr = a;
    wdat = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    d = rdat;
  endtask : rd_reg
  task automatic hold_len();
    busy = 1'b1;
    cyc(2);
    busy = 1'b0;
    c = 0;
    cyc(1);
    while (hreq === 1'b1 && c < 3000) begin
      c++;
      cyc(1);
    end
  endtask : hold_len
  task automatic period();
    repeat (2) begin
      for (n = 0; n < 40 && pclk !== 1'b0; n++) cyc(1);
      for (n = 0; n < 40 && pclk !== 1'b1; n++) cyc(1);
      for (hi = 0; hi < 40 && pclk === 1'b1; hi++) cyc(1);
      for (tot = hi; tot < 80 && pclk === 1'b0; tot++) cyc(1);
    end
  endtask : period
  task automatic wait_stp(input logic lvl);
    for (n = 0; n < 200 && stp !== lvl; n++) cyc(1);
  endtask : wait_stp
  task automatic pulse_irq();
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
  endtask : pulse_irq
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    cyc(20);
    arst_n = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(12);
    rd_reg(PCC_CTRL_ADDR, v);
    chk("reset value", v, 16'h1000);
    wr_reg(PCC_CTRL_ADDR, 16'hfff0);
    rd_reg(PCC_CTRL_ADDR, v);
    chk("reserved bits", v, 16'hfff0);
    rd_reg(16'h1073, v);
    chk("unmapped read", v, 16'h0000);
    $display("test registers done");
    wr_reg(PCC_CTRL_ADDR, 16'h1010);
    hold_len();
    chk("hold 1us", 16'(c), 16'd100);
    input_a = 1'b1;
    cyc(4);
    hold_len();
    chk("hold input_a", 16'(c), 16'd0);
    input_a = 1'b0;
    cyc(4);
    hold_len();
    chk("hold restored", 16'(c), 16'd100);
    wr_reg(PCC_CTRL_ADDR, 16'h10f0);
    hold_len();
    chk("hold 15us", 16'(c), 16'd1500);
    $display("test hold extension done");
    for (int k = 1; k <= 6; k++) begin
      wr_reg(PCC_CTRL_ADDR, {4'h1, 1'b0, 3'(k), 8'h00});
      period();
      chk("high time", 16'(hi), 16'(hig[k]));
      chk("period", 16'(tot), 16'(per[k]));
    end
    wr_reg(PCC_CTRL_ADDR, 16'h1200);
    input_a = 1'b1;
    period();
    chk("input_a period", 16'(tot), 16'd2);
    input_a = 1'b0;
    period();
    chk("alternate period", 16'(tot), 16'd4);
    wr_reg(PCC_CTRL_ADDR, 16'h1000);
    period();
    chk("nominal period", 16'(tot), 16'd2);
    $display("test clock speed done");
    wr_reg(PCC_CTRL_ADDR, 16'h1001);
    w_hold = 1'b1;
    wait_stp(1'b1);
    chk("stop on hold", 16'(stp), 16'h1);
    chk("stopped level", 16'(pclk), 16'h0);
    busy = 1'b1;
    cyc(1);
    chk("refresh while stopped", 16'(rreq), 16'h1);
    busy = 1'b0;
    nmi = 1'b1;
    cyc(1);
    nmi = 1'b0;
    cyc(4);
    chk("nmi restart", 16'(stp), 16'h0);
    rd_reg(PCC_CTRL_ADDR, v);
    chk("hold stop cleared", v, 16'h1000);
    w_hold = 1'b0;
    cyc(10);
    wr_reg(PCC_CTRL_ADDR, 16'h1002);
    w_halt = 1'b1;
    w_hold = 1'b1;
    wait_stp(1'b1);
    chk("stop on halt hold", 16'(stp), 16'h1);
    pulse_irq();
    wait_stp(1'b0);
    chk("irq restart", 16'(stp), 16'h0);
    wait_stp(1'b1);
    chk("stop again", 16'(stp), 16'h1);
    rd_reg(PCC_CTRL_ADDR, v);
    chk("halt hold bit kept", v, 16'h1002);
    wr_reg(PCC_CTRL_ADDR, 16'h1000);
    w_halt = 1'b0;
    w_hold = 1'b0;
    pulse_irq();
    cyc(10);
    chk("running", 16'(stp), 16'h0);
    $display("test clock stop done");
    wr_reg(PCC_CTRL_ADDR, 16'h17f3);
    mux_req = 1'b1;
    msel = 3'h2;
    sys_rst = 1'b1;
    cyc(4);
    chk("select in reset", 16'(mux_o), 16'h4);
    chk("pin driven in reset", 16'(oe), 16'h1);
    sys_rst = 1'b0;
    cyc(8);
    rd_reg(PCC_CTRL_ADDR, v);
    chk("strap high value", v, 16'h0000);
    cyc(30);
    chk("pin turned input", 16'(oe), 16'h0);
    chk("select passes", 16'(mux_o), 16'h2);
    $display("test system reset done");
    report_and_stop();
  end
endmodule : pcc_clock_ctrl_bench
